// [core/zcel_consts.svh]
// constants for the zero-cross event logic block
`ifndef ZCEL_CONSTS_SVH
`define ZCEL_CONSTS_SVH

`define ZCEL_ADDR_CTRL     12'h000
`define ZCEL_ADDR_STATUS   12'h004
`define ZCEL_ADDR_FLAG     12'h008
`define ZCEL_ADDR_MASK     12'h00C
`define ZCEL_ADDR_IRQCTL   12'h010

`define ZCEL_CTRL_ENABLE   0
`define ZCEL_CTRL_INVERT   1
`define ZCEL_CTRL_RISE     2
`define ZCEL_CTRL_FALL     3
`define ZCEL_IRQ_GROUP     0
`define ZCEL_IRQ_GLOBAL    1

`define ZCEL_HTRANS_NONSEQ 2'h2
`define ZCEL_HTRANS_SEQ    2'h3
`define ZCEL_HRESP_OKAY    1'h0

`endif

// [core/zcel_pkg.sv]
// types for the zero-cross event logic block
package zcel_pkg;

  typedef struct packed {
    logic fall_irq_enable;
    logic rise_irq_enable;
    logic invert_sense;
    logic enable;
  } zcel_ctrl_type;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
  } zcel_irqctl_type;

  typedef enum logic {
    ZCEL_BUS_IDLE,
    ZCEL_BUS_DATA
  } zcel_bus_state_type;

endpackage

// [core/zcel_top.sv]
// zero-cross detector back end with ahb-lite register slave
// Function
// - status is one while current sink active
// - polarity applies even when module disabled
// - invert set flips status meaning
// - edges detected on polarity-adjusted status
// - separate rising and falling edge detectors
// - enabled edge sets cross event flag
// - rise and fall enables gate edges
// - irq needs flag, peripheral, group, global enables
// - polarity change may raise an edge
// - set beats software clear same cycle
`timescale 1ns/1ps
`include "zcel_consts.svh"

module zcel_top (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_sink_active,
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_cross_state_bit,
  output logic             o_irq
);

  // ***********************************************
  // comparator synchroniser
  // ***********************************************
  logic sync1_q;
  logic sync2_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
    end else begin
      sync1_q <= i_sink_active;
      sync2_q <= sync1_q;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  zcel_pkg::zcel_ctrl_type      ctrl_q;
  zcel_pkg::zcel_irqctl_type    irqctl_q;
  zcel_pkg::zcel_bus_state_type bus_q;
  logic        flag_q;
  logic        mask_q;
  logic        state_q;
  logic        state_d;
  logic        prev_q;
  logic        rise_evt;
  logic        fall_evt;
  logic        set_evt;
  logic        wr_en;
  logic [11:0] addr_q;
  logic        write_q;

  // invert applies regardless of enable, so status is always live
  assign state_d = sync2_q ^ ctrl_q.invert_sense;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= 1'h0;
      prev_q  <= 1'h0;
    end else begin
      state_q <= state_d;
      prev_q  <= state_q;
    end
  end

  assign o_cross_state_bit = state_q;

  // edges on the adjusted signal, so an invert write is an edge too
  assign rise_evt = state_q & ~prev_q;
  assign fall_evt = ~state_q & prev_q;
  assign set_evt  = (rise_evt & ctrl_q.rise_irq_enable) |
                    (fall_evt & ctrl_q.fall_irq_enable);

  // ***********************************************
  // ahb-lite slave
  // ***********************************************
  logic        take;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign take = i_hsel & i_hready & i_htrans[1];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bus_q   <= zcel_pkg::ZCEL_BUS_IDLE;
      addr_q  <= 12'h000;
      write_q <= 1'h0;
    end else begin
      if (i_hready) begin
        case (bus_q)
          zcel_pkg::ZCEL_BUS_IDLE: begin
            if (take) begin
              bus_q <= zcel_pkg::ZCEL_BUS_DATA;
            end
          end
          zcel_pkg::ZCEL_BUS_DATA: begin
            if (!take) begin
              bus_q <= zcel_pkg::ZCEL_BUS_IDLE;
            end
          end
          default: bus_q <= zcel_pkg::ZCEL_BUS_IDLE;
        endcase
        if (take) begin
          addr_q  <= i_haddr;
          write_q <= i_hwrite;
        end
      end
    end
  end

  assign o_hreadyout = 1'h1;
  assign o_hresp     = `ZCEL_HRESP_OKAY;
  assign wr_en       = (bus_q == zcel_pkg::ZCEL_BUS_DATA) & write_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q   <= '0;
      irqctl_q <= '0;
      mask_q   <= 1'h0;
    end else if (wr_en) begin
      if (addr_q == `ZCEL_ADDR_CTRL) begin
        ctrl_q <= i_hwdata[3:0];
      end else if (addr_q == `ZCEL_ADDR_MASK) begin
        mask_q <= i_hwdata[0];
      end else if (addr_q == `ZCEL_ADDR_IRQCTL) begin
        irqctl_q <= i_hwdata[1:0];
      end
    end
  end

  // hardware never clears the flag; software writes one to clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_q <= 1'h0;
    end else if (set_evt) begin
      flag_q <= 1'h1;
    end else if (wr_en && addr_q == `ZCEL_ADDR_FLAG && i_hwdata[0]) begin
      flag_q <= 1'h0;
    end
  end

  // read mux decodes the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_haddr == `ZCEL_ADDR_CTRL) begin
      rdata_d[3:0] = ctrl_q;
    end else if (i_haddr == `ZCEL_ADDR_STATUS) begin
      rdata_d[0] = state_q;
    end else if (i_haddr == `ZCEL_ADDR_FLAG) begin
      rdata_d[0] = flag_q;
    end else if (i_haddr == `ZCEL_ADDR_MASK) begin
      rdata_d[0] = mask_q;
    end else if (i_haddr == `ZCEL_ADDR_IRQCTL) begin
      rdata_d[1:0] = irqctl_q;
    end
  end

  // latched at the address phase so read data leaves a flop;
  // limitation: a read pipelined behind a write sees the old value
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_hready) begin
      if (take && !i_hwrite) begin
        rdata_q <= rdata_d;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign o_hrdata = rdata_q;

  assign o_irq = flag_q & mask_q & irqctl_q.peripheral_group_irq_enable &
                 irqctl_q.global_irq_enable;

  // ***********************************************
  // assertions
  // ***********************************************
  property p_status;
    @(posedge i_clk) disable iff (i_reset)
      o_cross_state_bit == ($past(sync2_q) ^ $past(ctrl_q.invert_sense));
  endproperty
  a_status: assert property (p_status)
    else $error("status bit wrong");

  property p_rise_set;
    @(posedge i_clk) disable iff (i_reset)
      (rise_evt && ctrl_q.rise_irq_enable) |=> flag_q;
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rising edge did not set flag");

  property p_fall_set;
    @(posedge i_clk) disable iff (i_reset)
      (fall_evt && ctrl_q.fall_irq_enable) |=> flag_q;
  endproperty
  a_fall_set: assert property (p_fall_set)
    else $error("falling edge did not set flag");

  property p_no_spurious;
    @(posedge i_clk) disable iff (i_reset)
      (!flag_q && !set_evt) |=> !flag_q;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("flag set without enabled edge");

  property p_set_wins;
    @(posedge i_clk) disable iff (i_reset)
      (set_evt && wr_en && addr_q == `ZCEL_ADDR_FLAG) |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat set");

  property p_irq;
    @(posedge i_clk) disable iff (i_reset)
      o_irq == (flag_q && mask_q && irqctl_q == 2'h3);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq gating wrong");

  property p_invert_edge;
    @(posedge i_clk) disable iff (i_reset)
      ($stable(sync2_q) && $changed(ctrl_q.invert_sense)) |=>
        (rise_evt || fall_evt);
  endproperty
  a_invert_edge: assert property (p_invert_edge)
    else $error("invert change gave no edge");

  property p_sync1;
    @(posedge i_clk) disable iff (i_reset)
      sync1_q == $past(i_sink_active);
  endproperty
  a_sync1: assert property (p_sync1)
    else $error("first synchroniser stage wrong");

  property p_state_hold;
    @(posedge i_clk) disable iff (i_reset)
      ($stable(sync2_q) && $stable(ctrl_q.invert_sense)) |=>
        $stable(o_cross_state_bit);
  endproperty
  a_state_hold: assert property (p_state_hold)
    else $error("status moved without cause");

  property p_no_edge_steady;
    @(posedge i_clk) disable iff (i_reset)
      ($stable(sync2_q) && $stable(ctrl_q.invert_sense)) |=>
        !(rise_evt || fall_evt);
  endproperty
  a_no_edge_steady: assert property (p_no_edge_steady)
    else $error("edge without status change");

  property p_one_edge;
    @(posedge i_clk) disable iff (i_reset)
      rise_evt |-> !fall_evt;
  endproperty
  a_one_edge: assert property (p_one_edge)
    else $error("rise and fall together");

  property p_rise_dir;
    @(posedge i_clk) disable iff (i_reset)
      rise_evt |-> o_cross_state_bit;
  endproperty
  a_rise_dir: assert property (p_rise_dir)
    else $error("rising edge on low status");

  property p_fall_dir;
    @(posedge i_clk) disable iff (i_reset)
      fall_evt |-> !o_cross_state_bit;
  endproperty
  a_fall_dir: assert property (p_fall_dir)
    else $error("falling edge on high status");

  property p_rise_gate;
    @(posedge i_clk) disable iff (i_reset)
      (!flag_q && rise_evt && !ctrl_q.rise_irq_enable) |=> !flag_q;
  endproperty
  a_rise_gate: assert property (p_rise_gate)
    else $error("masked rising edge set flag");

  property p_fall_gate;
    @(posedge i_clk) disable iff (i_reset)
      (!flag_q && fall_evt && !ctrl_q.fall_irq_enable) |=> !flag_q;
  endproperty
  a_fall_gate: assert property (p_fall_gate)
    else $error("masked falling edge set flag");

  property p_flag_hold;
    @(posedge i_clk) disable iff (i_reset)
      (flag_q && !(wr_en && addr_q == `ZCEL_ADDR_FLAG && i_hwdata[0]))
        |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without software clear");

  property p_clear;
    @(posedge i_clk) disable iff (i_reset)
      (!set_evt && wr_en && addr_q == `ZCEL_ADDR_FLAG && i_hwdata[0])
        |=> !flag_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear flag");

  property p_irq_mask;
    @(posedge i_clk) disable iff (i_reset)
      !mask_q |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with peripheral enable off");

  property p_irq_group;
    @(posedge i_clk) disable iff (i_reset)
      !irqctl_q.peripheral_group_irq_enable |-> !o_irq;
  endproperty
  a_irq_group: assert property (p_irq_group)
    else $error("irq with group enable off");

  property p_irq_global;
    @(posedge i_clk) disable iff (i_reset)
      !irqctl_q.global_irq_enable |-> !o_irq;
  endproperty
  a_irq_global: assert property (p_irq_global)
    else $error("irq with global enable off");

  property p_write_ctrl;
    @(posedge i_clk) disable iff (i_reset)
      (wr_en && addr_q == `ZCEL_ADDR_CTRL) |=>
        ctrl_q == $past(i_hwdata[3:0]);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl)
    else $error("control write lost");

  // idle bus must not show stale read data
  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_reset)
      (bus_q == zcel_pkg::ZCEL_BUS_IDLE) |-> o_hrdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside data phase");

  property p_sync;
    @(posedge i_clk) disable iff (i_reset)
      sync2_q == $past(i_sink_active, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("synchroniser depth wrong");

endmodule

// [sim/tb.sv]
// self-checking bench for the zero-cross event logic
`timescale 1ns/1ps
`include "zcel_consts.svh"
module tb;
  logic        i_clk    = 1'b0;
  logic        i_reset  = 1'b1;
  logic        sink_req = 1'b0;
  logic        hsel     = 1'b0;
  logic [11:0] haddr    = 12'h000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        sink;
  logic        hrdy;
  logic        hresp;
  logic        state;
  logic        irq;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #4 i_clk = ~i_clk;

  zcel_comparator_model cmp_u (
    .i_sink_req(sink_req), .o_sink_active(sink));

  zcel_top dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_sink_active(sink),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_cross_state_bit(state), .o_irq(irq));

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // entered just after a rising edge, leaves just after one
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= `ZCEL_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // pins read mid-cycle, away from register updates
  task automatic sig(input string nm, input logic e, ref logic g);
    @(negedge i_clk);
    chk(nm, {31'h0, e}, {31'h0, g});
    @(posedge i_clk);
  endtask

  // 2 sync edges plus edge and flag stages fit well inside
  task automatic settle();
    repeat (8) @(posedge i_clk);
  endtask

  // ************************
  // scenarios
  // ************************
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd("reset", 12'(i * 4), 32'h0);
    sig("irq", 1'b0, irq);
  endtask

  task automatic t_polarity();
    sink_req <= 1'b1;
    settle();
    sig("state", 1'b1, state);
    rd("status", `ZCEL_ADDR_STATUS, 32'h1);
    wr(`ZCEL_ADDR_CTRL, 32'h2);
    settle();
    sig("state", 1'b0, state);
    rd("status", `ZCEL_ADDR_STATUS, 32'h0);
    rd("flag", `ZCEL_ADDR_FLAG, 32'h0);
    wr(`ZCEL_ADDR_CTRL, 32'h0);
    settle();
  endtask

  task automatic t_rise_irq();
    wr(`ZCEL_ADDR_CTRL, 32'h4);
    sink_req <= 1'b0;
    settle();
    rd("flag", `ZCEL_ADDR_FLAG, 32'h0);
    sink_req <= 1'b1;
    settle();
    rd("flag", `ZCEL_ADDR_FLAG, 32'h1);
    sig("irq", 1'b0, irq);
    wr(`ZCEL_ADDR_MASK, 32'h1);
    wr(`ZCEL_ADDR_IRQCTL, 32'h1);
    sig("irq", 1'b0, irq);
    wr(`ZCEL_ADDR_IRQCTL, 32'h2);
    sig("irq", 1'b0, irq);
    wr(`ZCEL_ADDR_IRQCTL, 32'h3);
    sig("irq", 1'b1, irq);
    wr(`ZCEL_ADDR_FLAG, 32'h1);
    rd("flag", `ZCEL_ADDR_FLAG, 32'h0);
    sig("irq", 1'b0, irq);
  endtask

  task automatic t_invert_edge();
    wr(`ZCEL_ADDR_CTRL, 32'h8);
    wr(`ZCEL_ADDR_CTRL, 32'hA);
    settle();
    rd("flag", `ZCEL_ADDR_FLAG, 32'h1);
    sig("irq", 1'b1, irq);
    wr(`ZCEL_ADDR_FLAG, 32'h1);
    sink_req <= 1'b0;
    settle();
    sig("state", 1'b1, state);
    rd("flag", `ZCEL_ADDR_FLAG, 32'h0);
  endtask

  // invert off gives a fall whose flag set meets the clear write
  task automatic t_set_wins();
    wr(`ZCEL_ADDR_CTRL, 32'hD);
    wr(`ZCEL_ADDR_FLAG, 32'h1);
    rd("flag", `ZCEL_ADDR_FLAG, 32'h1);
    rd("ctrl", `ZCEL_ADDR_CTRL, 32'hD);
    wr(`ZCEL_ADDR_FLAG, 32'h1);
    rd("flag", `ZCEL_ADDR_FLAG, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_polarity();
    t_rise_irq();
    t_invert_edge();
    t_set_wins();
    final_report();
  end
endmodule

// [sim/zcel_comparator_model.sv]
// comparator stage model: current sink or source indication
`timescale 1ns/1ps
module zcel_comparator_model (
  input  wire logic i_sink_req,
  output logic      o_sink_active
);
  // skewed off the clock edge: the real stage is asynchronous
  initial o_sink_active = 1'b0;
  always @(i_sink_req) o_sink_active <= #3 i_sink_req;
endmodule
